// ===== eld_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "eld_defs.svh"
module eld_decoder (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] memRData,
  input wire logic [15:0] firstIndexReg,
  input wire logic [15:0] secondIndexReg,
  input wire logic interruptEnableLatch,
  output logic [15:0] busAddr,
  output logic busRd,
  output logic busWr,
  output logic [7:0] busWData,
  output logic instrDone,
  output logic instrUnsupported,
  output logic [7:0][7:0] regView,
  output logic [7:0] flags,
  output logic [7:0] intVector,
  output logic [7:0] refreshCount,
  output logic [15:0] progCounter
);

  eld_pkg::eld_core_t cur;
  eld_pkg::eld_core_t next_cur;
  eld_pkg::eld_form_t decF;
  logic regWrEn;
  logic [2:0] regWrSel;
  logic [7:0] regWrData;
  logic flLoad;
  logic [7:0] accVal;
  logic [15:0] idxBase;
  logic [15:0] effAddr;
  logic [7:0] wrVal;

  // -------------------------------------------------------------
  // opcode classification
  // -------------------------------------------------------------
  function automatic eld_pkg::eld_form_t decode(
    input eld_pkg::eld_pre_t pre,
    input logic [7:0] op
  );
    logic idx;
    logic [2:0] dst;
    logic [2:0] src;
    eld_pkg::eld_form_t f;
    idx = (pre == eld_pkg::ELD_PRE_FIRST) ||
          (pre == eld_pkg::ELD_PRE_SECOND);
    dst = op[5:3];
    src = op[2:0];
    f = eld_pkg::ELD_F_BAD;
    if (pre == eld_pkg::ELD_PRE_EXT)
    begin
      if (op == `ELD_OP_A_IV || op == `ELD_OP_A_RF)
        f = eld_pkg::ELD_F_AIR;
      else if (op == `ELD_OP_IV_A || op == `ELD_OP_RF_A)
        f = eld_pkg::ELD_F_IRA;
    end
    else if (op[7:6] == `ELD_TOP_RR)
    begin
      if (dst == `ELD_CODE_MEM && src == `ELD_CODE_MEM)
        f = eld_pkg::ELD_F_BAD;
      else if (src == `ELD_CODE_MEM)
        f = idx ? eld_pkg::ELD_F_RX : eld_pkg::ELD_F_RM;
      else if (dst == `ELD_CODE_MEM)
        f = idx ? eld_pkg::ELD_F_XR : eld_pkg::ELD_F_MR;
      else if (!idx)
        f = eld_pkg::ELD_F_RR;
    end
    else if (op[7:6] == `ELD_TOP_IMM)
    begin
      if (op == `ELD_OP_MN)
        f = idx ? eld_pkg::ELD_F_XN : eld_pkg::ELD_F_MN;
      else if (!idx)
      begin
        if (src == `ELD_CODE_MEM)
          f = eld_pkg::ELD_F_RI;
        else if (op == `ELD_OP_LDA_FG || op == `ELD_OP_LDA_SG)
          f = eld_pkg::ELD_F_AP;
        else if (op == `ELD_OP_STA_FG || op == `ELD_OP_STA_SG)
          f = eld_pkg::ELD_F_PA;
        else if (op == `ELD_OP_LDA_NN)
          f = eld_pkg::ELD_F_AD;
        else if (op == `ELD_OP_STA_NN)
          f = eld_pkg::ELD_F_DA;
      end
    end
    return f;
  endfunction

  // clock states of each form
  function automatic logic [4:0] tstates(input eld_pkg::eld_form_t f);
    case (f)
      eld_pkg::ELD_F_RI, eld_pkg::ELD_F_RM, eld_pkg::ELD_F_MR,
      eld_pkg::ELD_F_AP, eld_pkg::ELD_F_PA:
        tstates = `ELD_T_TWO;
      eld_pkg::ELD_F_RX, eld_pkg::ELD_F_XR, eld_pkg::ELD_F_XN:
        tstates = `ELD_T_IDX;
      eld_pkg::ELD_F_MN:
        tstates = `ELD_T_MN;
      eld_pkg::ELD_F_AD, eld_pkg::ELD_F_DA:
        tstates = `ELD_T_DIR;
      eld_pkg::ELD_F_AIR, eld_pkg::ELD_F_IRA:
        tstates = `ELD_T_IR;
      default:
        tstates = `ELD_T_RR;
    endcase
  endfunction

  // start a memory read in the following cycle
  function automatic eld_pkg::eld_core_t rd(
    input eld_pkg::eld_core_t s,
    input eld_pkg::eld_cap_t c,
    input logic [15:0] a
  );
    eld_pkg::eld_core_t t;
    t = s;
    t.st = eld_pkg::ELD_ST_RDREQ;
    t.cap = c;
    t.busRd = 1'b1;
    t.busAddr = a;
    return t;
  endfunction

  // -------------------------------------------------------------
  // operand paths
  // -------------------------------------------------------------
  assign decF = decode(cur.pre, memRData);
  assign accVal = regView[`ELD_CODE_A];
  assign idxBase = (cur.pre == eld_pkg::ELD_PRE_SECOND) ?
                   secondIndexReg : firstIndexReg;

  // effective address per form
  always_comb
  begin
    case (cur.form)
      eld_pkg::ELD_F_RX, eld_pkg::ELD_F_XR, eld_pkg::ELD_F_XN:
        effAddr = idxBase + {{8{cur.disp[7]}}, cur.disp};
      eld_pkg::ELD_F_AP, eld_pkg::ELD_F_PA:
        effAddr = cur.op[4] ?
          {regView[`ELD_CODE_D], regView[`ELD_CODE_E]} :
          {regView[`ELD_CODE_B], regView[`ELD_CODE_C]};
      eld_pkg::ELD_F_AD, eld_pkg::ELD_F_DA:
        effAddr = {cur.ahi, cur.alo};
      default:
        effAddr = {regView[`ELD_CODE_H], regView[`ELD_CODE_L]};
    endcase
  end

  // byte to store per form
  always_comb
  begin
    case (cur.form)
      eld_pkg::ELD_F_MN, eld_pkg::ELD_F_XN:
        wrVal = cur.imm;
      eld_pkg::ELD_F_PA, eld_pkg::ELD_F_DA:
        wrVal = accVal;
      default:
        wrVal = regView[cur.op[2:0]];
    endcase
  end

  // -------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------
  always_comb
  begin
    next_cur = cur;
    next_cur.done = 1'b0;
    next_cur.bad = 1'b0;
    next_cur.busRd = 1'b0;
    next_cur.busWr = 1'b0;
    regWrEn = 1'b0;
    regWrSel = cur.op[5:3];
    regWrData = memRData;
    flLoad = 1'b0;
    case (cur.st)
      eld_pkg::ELD_ST_FETCH:
      begin
        next_cur.pre = eld_pkg::ELD_PRE_NONE;
        next_cur.form = eld_pkg::ELD_F_BAD;
        next_cur.total = `ELD_T_RR;
        next_cur = rd(next_cur, eld_pkg::ELD_CAP_OP, cur.pc);
      end
      eld_pkg::ELD_ST_RDREQ:
        next_cur.st = eld_pkg::ELD_ST_RDDATA;
      eld_pkg::ELD_ST_RDDATA:
      begin
        if (cur.cap != eld_pkg::ELD_CAP_MEM)
          next_cur.pc = cur.pc + `ELD_ONE16;
        case (cur.cap)
          eld_pkg::ELD_CAP_OP, eld_pkg::ELD_CAP_OP2:
          begin
            // refresh counter steps on each opcode fetch, bit 7 held
            next_cur.rf = {cur.rf[7], cur.rf[6:0] + `ELD_ONE7};
            if (cur.cap == eld_pkg::ELD_CAP_OP &&
                (memRData == `ELD_PFX_FIRST ||
                 memRData == `ELD_PFX_SECOND ||
                 memRData == `ELD_PFX_EXT))
            begin
              if (memRData == `ELD_PFX_FIRST)
                next_cur.pre = eld_pkg::ELD_PRE_FIRST;
              else if (memRData == `ELD_PFX_SECOND)
                next_cur.pre = eld_pkg::ELD_PRE_SECOND;
              else
                next_cur.pre = eld_pkg::ELD_PRE_EXT;
              next_cur = rd(next_cur, eld_pkg::ELD_CAP_OP2, next_cur.pc);
            end
            else
            begin
              next_cur.op = memRData;
              next_cur.form = decF;
              next_cur.total = tstates(decF);
              case (decF)
                eld_pkg::ELD_F_RX, eld_pkg::ELD_F_XR, eld_pkg::ELD_F_XN:
                  next_cur = rd(next_cur, eld_pkg::ELD_CAP_DISP,
                                next_cur.pc);
                eld_pkg::ELD_F_RI, eld_pkg::ELD_F_MN:
                  next_cur = rd(next_cur, eld_pkg::ELD_CAP_IMM,
                                next_cur.pc);
                eld_pkg::ELD_F_AD, eld_pkg::ELD_F_DA:
                  next_cur = rd(next_cur, eld_pkg::ELD_CAP_ALO,
                                next_cur.pc);
                eld_pkg::ELD_F_BAD:
                begin
                  // unknown byte: finish at once and flag it
                  next_cur.bad = 1'b1;
                  next_cur.total = cur.tcnt + `ELD_ONE5;
                  next_cur.st = eld_pkg::ELD_ST_PAD;
                end
                default:
                  next_cur.st = eld_pkg::ELD_ST_ACT;
              endcase
            end
          end
          eld_pkg::ELD_CAP_DISP:
          begin
            next_cur.disp = memRData;
            if (cur.form == eld_pkg::ELD_F_XN)
              next_cur = rd(next_cur, eld_pkg::ELD_CAP_IMM,
                            next_cur.pc);
            else
              next_cur.st = eld_pkg::ELD_ST_ACT;
          end
          eld_pkg::ELD_CAP_IMM:
          begin
            next_cur.imm = memRData;
            next_cur.st = eld_pkg::ELD_ST_ACT;
          end
          eld_pkg::ELD_CAP_ALO:
          begin
            next_cur.alo = memRData;
            next_cur = rd(next_cur, eld_pkg::ELD_CAP_AHI, next_cur.pc);
          end
          eld_pkg::ELD_CAP_AHI:
          begin
            next_cur.ahi = memRData;
            next_cur.st = eld_pkg::ELD_ST_ACT;
          end
          default:
          begin
            // memory byte into its register
            regWrEn = 1'b1;
            if (cur.form == eld_pkg::ELD_F_AP ||
                cur.form == eld_pkg::ELD_F_AD)
              regWrSel = `ELD_CODE_A;
            next_cur.st = eld_pkg::ELD_ST_PAD;
          end
        endcase
      end
      eld_pkg::ELD_ST_ACT:
      begin
        next_cur.st = eld_pkg::ELD_ST_PAD;
        case (cur.form)
          eld_pkg::ELD_F_RR:
          begin
            regWrEn = 1'b1;
            regWrData = regView[cur.op[2:0]];
          end
          eld_pkg::ELD_F_RI:
          begin
            regWrEn = 1'b1;
            regWrData = cur.imm;
          end
          eld_pkg::ELD_F_RM, eld_pkg::ELD_F_RX, eld_pkg::ELD_F_AP,
          eld_pkg::ELD_F_AD:
            next_cur = rd(next_cur, eld_pkg::ELD_CAP_MEM, effAddr);
          eld_pkg::ELD_F_AIR:
          begin
            regWrEn = 1'b1;
            regWrSel = `ELD_CODE_A;
            regWrData = cur.op[3] ? cur.rf : cur.iv;
            flLoad = 1'b1;
          end
          eld_pkg::ELD_F_IRA:
          begin
            if (cur.op[3])
              next_cur.rf = accVal;
            else
              next_cur.iv = accVal;
          end
          eld_pkg::ELD_F_BAD:
            next_cur.st = eld_pkg::ELD_ST_PAD;
          default:
          begin
            // every store form writes one byte
            next_cur.st = eld_pkg::ELD_ST_WR;
            next_cur.busWr = 1'b1;
            next_cur.busAddr = effAddr;
            next_cur.busWData = wrVal;
          end
        endcase
      end
      eld_pkg::ELD_ST_WR:
        next_cur.st = eld_pkg::ELD_ST_PAD;
      eld_pkg::ELD_ST_PAD:
        next_cur.st = eld_pkg::ELD_ST_PAD;
      default:
        next_cur.st = eld_pkg::ELD_ST_FETCH;
    endcase
    // pad until the form's clock-state count is used up
    next_cur.tcnt = cur.tcnt + `ELD_ONE5;
    if (next_cur.st == eld_pkg::ELD_ST_PAD &&
        cur.tcnt == next_cur.total - `ELD_ONE5)
    begin
      next_cur.st = eld_pkg::ELD_ST_FETCH;
      next_cur.tcnt = `ELD_ZERO5;
      next_cur.done = 1'b1;
    end
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cur <= '0;
      cur.pc <= `ELD_RST_PC;
      cur.total <= `ELD_T_RR;
    end
    else
      cur <= next_cur;
  end

  // general registers, 110 is never written
  eld_regfile u_regs (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .wrEn(regWrEn),
    .wrSel(regWrSel),
    .wrData(regWrData),
    .regView(regView)
  );

  // condition flags; only vector/refresh reads touch them
  eld_flags u_flags (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .load(flLoad),
    .result(regWrData),
    .iffIn(interruptEnableLatch),
    .flags(flags)
  );

  // outputs straight from the state register
  assign busAddr = cur.busAddr;
  assign busRd = cur.busRd;
  assign busWr = cur.busWr;
  assign busWData = cur.busWData;
  assign instrDone = cur.done;
  assign instrUnsupported = cur.bad;
  assign intVector = cur.iv;
  assign refreshCount = cur.rf;
  assign progCounter = cur.pc;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  logic [4:0] lenCnt;

  // cycles since the last instruction end
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      lenCnt <= `ELD_ZERO5;
    else if (cur.done)
      lenCnt <= `ELD_ONE5;
    else
      lenCnt <= lenCnt + `ELD_ONE5;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  AST_RR_TIME: assert property (
    instrDone && cur.form == eld_pkg::ELD_F_RR |-> lenCnt == `ELD_T_RR)
    else $error("register copy length wrong");
  AST_RI_TIME: assert property (
    instrDone && cur.form == eld_pkg::ELD_F_RI |-> lenCnt == `ELD_T_TWO)
    else $error("immediate load length wrong");
  AST_RM_TIME: assert property (
    instrDone && cur.form == eld_pkg::ELD_F_RM |-> lenCnt == `ELD_T_TWO)
    else $error("pointer load length wrong");
  AST_RX_TIME: assert property (
    instrDone && cur.form == eld_pkg::ELD_F_RX |-> lenCnt == `ELD_T_IDX)
    else $error("indexed load length wrong");
  AST_XR_TIME: assert property (
    instrDone && cur.form == eld_pkg::ELD_F_XR |-> lenCnt == `ELD_T_IDX)
    else $error("indexed store length wrong");
  AST_MN_TIME: assert property (
    instrDone && cur.form == eld_pkg::ELD_F_MN |-> lenCnt == `ELD_T_MN)
    else $error("pointer immediate store length wrong");
  AST_XN_TIME: assert property (
    instrDone && cur.form == eld_pkg::ELD_F_XN |-> lenCnt == `ELD_T_IDX)
    else $error("indexed immediate store length wrong");
  AST_PAIR_TIME: assert property (
    instrDone && (cur.form == eld_pkg::ELD_F_AP ||
    cur.form == eld_pkg::ELD_F_PA) |-> lenCnt == `ELD_T_TWO)
    else $error("pair accumulator length wrong");
  AST_DIR_TIME: assert property (
    instrDone && (cur.form == eld_pkg::ELD_F_AD ||
    cur.form == eld_pkg::ELD_F_DA) |-> lenCnt == `ELD_T_DIR)
    else $error("direct accumulator length wrong");
  AST_IR_TIME: assert property (
    instrDone && (cur.form == eld_pkg::ELD_F_AIR ||
    cur.form == eld_pkg::ELD_F_IRA) |-> lenCnt == `ELD_T_IR)
    else $error("vector/refresh transfer length wrong");
  AST_MR_TIME: assert property (
    busWr && cur.form == eld_pkg::ELD_F_MR |->
    busAddr == {regView[`ELD_CODE_H], regView[`ELD_CODE_L]}
    ##[1:6] instrDone)
    else $error("pointer store address or length wrong");
  AST_DA_ADDR: assert property (
    busWr && cur.form == eld_pkg::ELD_F_DA |->
    busAddr == {cur.ahi, cur.alo} && busWData == accVal)
    else $error("direct store address order wrong");

  COV_RR: cover property (instrDone && cur.form == eld_pkg::ELD_F_RR);
  COV_XN: cover property (instrDone && cur.form == eld_pkg::ELD_F_XN);
  COV_AIR: cover property (instrDone && cur.form == eld_pkg::ELD_F_AIR);
  COV_BAD: cover property (instrUnsupported);

endmodule
`default_nettype wire

// ===== eld_defs.svh
`ifndef ELD_DEFS_SVH
`define ELD_DEFS_SVH

// prefix bytes
`define ELD_PFX_FIRST 8'hDD
`define ELD_PFX_SECOND 8'hFD
`define ELD_PFX_EXT 8'hED

// register field codes
`define ELD_CODE_B 3'h0
`define ELD_CODE_C 3'h1
`define ELD_CODE_D 3'h2
`define ELD_CODE_E 3'h3
`define ELD_CODE_H 3'h4
`define ELD_CODE_L 3'h5
`define ELD_CODE_MEM 3'h6
`define ELD_CODE_A 3'h7

// opcode top fields and whole opcodes
`define ELD_TOP_RR 2'h1
`define ELD_TOP_IMM 2'h0
`define ELD_OP_MN 8'h36
`define ELD_OP_LDA_FG 8'h0A
`define ELD_OP_LDA_SG 8'h1A
`define ELD_OP_STA_FG 8'h02
`define ELD_OP_STA_SG 8'h12
`define ELD_OP_LDA_NN 8'h3A
`define ELD_OP_STA_NN 8'h32
`define ELD_OP_A_IV 8'h57
`define ELD_OP_A_RF 8'h5F
`define ELD_OP_IV_A 8'h47
`define ELD_OP_RF_A 8'h4F

// clock states per instruction form
`define ELD_T_RR 5'h04
`define ELD_T_TWO 5'h07
`define ELD_T_MN 5'h0A
`define ELD_T_IDX 5'h13
`define ELD_T_DIR 5'h0D
`define ELD_T_IR 5'h09

// flag bit positions
`define ELD_FL_S 7
`define ELD_FL_Z 6
`define ELD_FL_H 4
`define ELD_FL_PV 2
`define ELD_FL_N 1

// reset values and increment constants
`define ELD_RST_PC 16'h0000
`define ELD_RST_BYTE 8'h00
`define ELD_ONE16 16'h0001
`define ELD_ONE7 7'h01
`define ELD_ONE5 5'h01
`define ELD_ZERO5 5'h00

`endif

// ===== eld_pkg.sv
`default_nettype none
package eld_pkg;

  typedef enum logic [2:0] {
    ELD_ST_FETCH = 3'b000,
    ELD_ST_RDREQ = 3'b001,
    ELD_ST_RDDATA = 3'b010,
    ELD_ST_ACT = 3'b011,
    ELD_ST_WR = 3'b100,
    ELD_ST_PAD = 3'b101
  } eld_state_t;

  typedef enum logic [2:0] {
    ELD_CAP_OP = 3'b000,
    ELD_CAP_OP2 = 3'b001,
    ELD_CAP_DISP = 3'b010,
    ELD_CAP_IMM = 3'b011,
    ELD_CAP_ALO = 3'b100,
    ELD_CAP_AHI = 3'b101,
    ELD_CAP_MEM = 3'b110
  } eld_cap_t;

  typedef enum logic [1:0] {
    ELD_PRE_NONE = 2'b00,
    ELD_PRE_FIRST = 2'b01,
    ELD_PRE_SECOND = 2'b10,
    ELD_PRE_EXT = 2'b11
  } eld_pre_t;

  typedef enum logic [3:0] {
    ELD_F_BAD = 4'b0000,
    ELD_F_RR = 4'b0001,
    ELD_F_RI = 4'b0010,
    ELD_F_RM = 4'b0011,
    ELD_F_RX = 4'b0100,
    ELD_F_MR = 4'b0101,
    ELD_F_XR = 4'b0110,
    ELD_F_MN = 4'b0111,
    ELD_F_XN = 4'b1000,
    ELD_F_AP = 4'b1001,
    ELD_F_PA = 4'b1010,
    ELD_F_AD = 4'b1011,
    ELD_F_DA = 4'b1100,
    ELD_F_AIR = 4'b1101,
    ELD_F_IRA = 4'b1110
  } eld_form_t;

  typedef struct packed {
    eld_state_t st;
    eld_cap_t cap;
    eld_form_t form;
    eld_pre_t pre;
    logic [7:0] op;
    logic [7:0] disp;
    logic [7:0] imm;
    logic [7:0] alo;
    logic [7:0] ahi;
    logic [15:0] pc;
    logic [7:0] iv;
    logic [7:0] rf;
    logic [4:0] tcnt;
    logic [4:0] total;
    logic [15:0] busAddr;
    logic busRd;
    logic busWr;
    logic [7:0] busWData;
    logic done;
    logic bad;
  } eld_core_t;

  typedef struct packed {
    logic [7:0][7:0] r;
  } eld_rf_t;

  typedef struct packed {
    logic [7:0] f;
  } eld_flag_t;

endpackage
`default_nettype wire

// ===== eld_regfile.sv
`timescale 1ns/1ps
`default_nettype none
`include "eld_defs.svh"
module eld_regfile (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wrEn,
  input wire logic [2:0] wrSel,
  input wire logic [7:0] wrData,
  output logic [7:0][7:0] regView
);

  eld_pkg::eld_rf_t cur;
  eld_pkg::eld_rf_t next_cur;

  // one write port, every register visible
  always_comb
  begin
    next_cur = cur;
    if (wrEn && wrSel != `ELD_CODE_MEM)
      next_cur.r[wrSel] = wrData;
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      cur <= '0;
    else
      cur <= next_cur;
  end

  assign regView = cur.r;

  AST_NO_MEMCODE: assert property (@(posedge ref_clk) disable iff (!nrst)
    wrEn |-> wrSel != `ELD_CODE_MEM)
    else $error("write aimed at the memory operand code");

endmodule
`default_nettype wire

// ===== eld_flags.sv
`timescale 1ns/1ps
`default_nettype none
`include "eld_defs.svh"
module eld_flags (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [7:0] result,
  input wire logic iffIn,
  output logic [7:0] flags
);

  eld_pkg::eld_flag_t cur;
  eld_pkg::eld_flag_t next_cur;

  // vector/refresh read into accumulator updates flags, carry kept
  always_comb
  begin
    next_cur = cur;
    if (load)
    begin
      next_cur.f[`ELD_FL_S] = result[7];
      next_cur.f[`ELD_FL_Z] = (result == `ELD_RST_BYTE);
      next_cur.f[`ELD_FL_H] = 1'b0;
      next_cur.f[`ELD_FL_PV] = iffIn;
      next_cur.f[`ELD_FL_N] = 1'b0;
    end
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      cur <= '0;
    else
      cur <= next_cur;
  end

  assign flags = cur.f;

  AST_FLAG_IR: assert property (@(posedge ref_clk) disable iff (!nrst)
    load |=> flags[`ELD_FL_PV] == $past(iffIn) && !flags[`ELD_FL_N]
      && flags[0] == $past(flags[0]))
    else $error("vector/refresh load flags wrong");
  AST_FLAG_KEEP: assert property (@(posedge ref_clk) disable iff (!nrst)
    !load |=> $stable(flags))
    else $error("flags changed by a plain load");

endmodule
`default_nettype wire

// ===== eld_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// program and data memory on the bus
// ----------------------------------------
module eld_mem_model (
  input wire logic ref_clk,
  input wire logic [15:0] busAddr,
  input wire logic busRd,
  input wire logic busWr,
  input wire logic [7:0] busWData,
  output logic [7:0] memRData
);
  logic [7:0] mem [0:65535];
  initial memRData = 8'h00;
  // answer one cycle after a read, otherwise show a moving pattern
  always @(posedge ref_clk)
  begin
    if (busWr)
      mem[busAddr] <= busWData;
    if (busRd)
      memRData <= mem[busAddr];
    else
      memRData <= ~memRData;
  end
endmodule
`default_nettype wire

// ===== eld_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module eld_decoder_tb_top;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] memRData;
  logic [15:0] busAddr;
  logic busRd, busWr, instrDone, instrUnsupported;
  logic [7:0] busWData, flags, intVector;
  logic [7:0][7:0] regView;
  int miscompares = 0;
  int comparisons = 0;
  int n;
  logic [7:0] prog [0:43] = '{8'h3E, 8'h5A, 8'h47, 8'h26, 8'h00, 8'h2E,
    8'h80, 8'h70, 8'h4E, 8'h36, 8'hC3, 8'h7E, 8'hDD, 8'h56, 8'hFE, 8'hFD,
    8'h5E, 8'h01, 8'hDD, 8'h77, 8'h03, 8'hFD, 8'h36, 8'h02, 8'h44, 8'h32,
    8'hB0, 8'h00, 8'h3A, 8'h91, 8'h00, 8'hED, 8'h47, 8'hED, 8'h4F, 8'h0A,
    8'h12, 8'hED, 8'h5F, 8'hED, 8'h57, 8'h02, 8'h1A, 8'h76};
  int dur [0:20] = '{4, 7, 7, 7, 7, 10, 7, 19, 19, 19, 19, 13, 13, 9, 9, 7,
    7, 9, 9, 7, 7};
  logic iffLatch = 1'b0;
  logic iffSet = 1'b0;
  logic [7:0] refreshCount;
  logic [15:0] progCounter;
  // clock
  always #10 ref_clk = ~ref_clk;
  // enable latch level applied on a rising edge
  always @(posedge ref_clk) iffLatch <= iffSet;
  eld_decoder eld_decoder_inst (.ref_clk(ref_clk), .nrst(nrst),
    .memRData(memRData), .firstIndexReg(16'h0092),
    .secondIndexReg(16'h00A0), .interruptEnableLatch(iffLatch),
    .busAddr(busAddr), .busRd(busRd), .busWr(busWr), .busWData(busWData),
    .instrDone(instrDone), .instrUnsupported(instrUnsupported),
    .regView(regView), .flags(flags), .intVector(intVector),
    .refreshCount(refreshCount), .progCounter(progCounter));
  eld_mem_model eld_mem_model_inst (.ref_clk(ref_clk), .busAddr(busAddr),
    .busRd(busRd), .busWr(busWr), .busWData(busWData),
    .memRData(memRData));
  // compare and count
  task check(input logic [15:0] seen, input logic [15:0] exp,
    input string what);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // count clock states up to the next completion pulse
  task next_done;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    while (instrDone !== 1'b1 && n < 40);
  endtask
  // watchdog
  initial
  begin
    #100us;
    miscompares++;
    conclude();
  end
  // main sequence
  initial
  begin
    #1;
    foreach (prog[i]) eld_mem_model_inst.mem[i] = prog[i];
    eld_mem_model_inst.mem[16'h0090] = 8'h11;
    eld_mem_model_inst.mem[16'h0091] = 8'h33;
    eld_mem_model_inst.mem[16'h00A1] = 8'h22;
    eld_mem_model_inst.mem[16'h5A5A] = 8'h66;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    next_done();
    for (int k = 0; k < 22; k++)
    begin
      next_done();
      if (k < 21)
      begin
        check(16'(n), 16'(dur[k]), "states");
        check({15'h0000, instrUnsupported}, 16'h0000, "unsupported");
      end
      if (k < 17)
        check({8'h00, flags}, 16'h0000, "flags");
      if (k == 17)
      begin
        check({15'h0000, flags[2]}, 16'h0000, "pv");
        check({8'h00, flags}, 16'h0000, "flags ar");
        check({8'h00, regView[7]}, 16'h0037, "a from refresh");
        iffSet = 1'b1;
      end
      if (k == 18)
      begin
        check({8'h00, flags}, 16'h0004, "flags ai");
        check({8'h00, regView[7]}, 16'h0033, "a from vector");
      end
      if (k == 19 || k == 20)
        check({8'h00, flags}, 16'h0004, "flags kept");
      if (k == 21)
        check({15'h0000, instrUnsupported}, 16'h0001, "unsupported");
    end
    check({8'h00, regView[0]}, 16'h005A, "b");
    check({8'h00, regView[1]}, 16'h005A, "c");
    check({8'h00, regView[2]}, 16'h0011, "d");
    check({8'h00, regView[3]}, 16'h0022, "e");
    check({8'h00, regView[4]}, 16'h0000, "h");
    check({8'h00, regView[5]}, 16'h0080, "l");
    check({8'h00, regView[7]}, 16'h0066, "a");
    check({8'h00, intVector}, 16'h0033, "vector");
    check({8'h00, eld_mem_model_inst.mem[16'h0080]}, 16'h00C3, "m80");
    check({8'h00, eld_mem_model_inst.mem[16'h0095]}, 16'h00C3, "m95");
    check({8'h00, eld_mem_model_inst.mem[16'h00A2]}, 16'h0044, "mA2");
    check({8'h00, eld_mem_model_inst.mem[16'h00B0]}, 16'h00C3, "mB0");
    check({8'h00, eld_mem_model_inst.mem[16'h1122]}, 16'h0066,
      "m1122");
    check({8'h00, eld_mem_model_inst.mem[16'h5A5A]}, 16'h0033,
      "m5A5A");
    check({8'h00, refreshCount}, 16'h003C, "refresh");
    check(progCounter, 16'h002C, "pc");
    conclude();
  end
endmodule
`default_nettype wire
